// >>> rtl/adc_acquisition_clock_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module adc_acquisition_clock_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] acquisition_time_select,
  input  wire logic [2:0] conversion_clock_select,
  input  wire logic       go_set,
  input  wire logic       go_clear,
  input  wire logic       done_clear,
  input  wire logic       rc_tick,
  input  wire logic       compare_in,
  output logic            go_flag,
  output logic            conversion_done_flag,
  output logic            sample_enable,
  output logic            convert_active,
  output logic            bit_clock,
  output logic [9:0]      result_register_pair,
  output logic [2:0]      acq_sel_reg,
  output logic [2:0]      clk_sel_reg
);
  // ------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rst_sync <= 2'h0;
    else          rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // RC oscillator tick and comparator are asynchronous to ref_clk
  logic [1:0] rc_s1, rc_s2;
  logic       rc_prev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_s1   <= 2'h0;
      rc_s2   <= 2'h0;
      rc_prev <= 1'b0;
    end else begin
      rc_s1   <= {rc_s1[0], rc_tick};
      rc_s2   <= {rc_s2[0], compare_in};
      rc_prev <= rc_s1[1];
    end
  end
  logic rc_edge;
  assign rc_edge = rc_s1[1] & ~rc_prev;

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  logic [2:0] acq_sel_next, clk_sel_next;
  always_comb begin
    acq_sel_next = acquisition_time_select;
    clk_sel_next = conversion_clock_select;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_sel_reg <= ACQ_RESET;
      clk_sel_reg <= CLK_SEL_RESET;
    end else begin
      acq_sel_reg <= acq_sel_next;
      clk_sel_reg <= clk_sel_next;
    end
  end

  logic use_rc;
  assign use_rc = (clk_sel_reg[1:0] == 2'h3);

  // ------------------------------------------------------------
  // Bit-period divider: one pulse per bit_conversion_period
  // ------------------------------------------------------------
  seq_state_t state_reg, state_next;
  logic [6:0] div_reg, div_next;
  logic       bclk_reg, bclk_next;
  logic       period_tick;
  logic       clk_run;
  assign clk_run = (state_reg != ST_SAMPLE) && (state_reg != ST_RC_WAIT);
  logic       go_reg, go_next, done_reg, done_next;
  logic       abort_req;
  // An abort restarts the divider so the gap spans two whole periods
  assign abort_req = go_clear && !go_set && go_reg &&
                     (state_reg != ST_SAMPLE) && (state_reg != ST_GAP);

  always_comb begin
    div_next    = div_reg;
    bclk_next   = bclk_reg;
    period_tick = 1'b0;
    if (!clk_run || abort_req) begin
      div_next  = 7'h00;
      bclk_next = 1'b0;
    end else if (use_rc) begin
      if (rc_edge) begin
        bclk_next   = ~bclk_reg;
        period_tick = bclk_reg;
      end
    end else if (div_reg >= div_last(clk_sel_reg)) begin
      div_next    = 7'h00;
      bclk_next   = ~bclk_reg;
      period_tick = bclk_reg;
    end else begin
      div_next = div_reg + 7'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 7'h00;
      bclk_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      bclk_reg <= bclk_next;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [4:0] cnt_reg, cnt_next;
  logic [6:0] dly_reg, dly_next;
  logic [9:0] res_reg, res_next, sar_reg, sar_next;
  logic       go_rise;
  assign go_rise = go_set & ~go_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    dly_next   = dly_reg;
    go_next    = go_reg;
    done_next  = done_reg & ~done_clear;
    res_next   = res_reg;
    sar_next   = sar_reg;
    if (go_set) go_next = 1'b1;
    // Software clear aborts; a clear alongside a set keeps the set
    if (go_clear && !go_set && go_reg) begin
      go_next = 1'b0;
      if (state_reg != ST_SAMPLE && state_reg != ST_GAP) begin
        state_next = ST_GAP;
        cnt_next   = 5'h00;
      end
    end else begin
      case (state_reg)
        ST_SAMPLE: begin
          if (go_rise) begin
            cnt_next = 5'h00;
            sar_next = 10'h000;
            if (use_rc) begin
              state_next = ST_RC_WAIT;
              dly_next   = INSTR_DELAY;
            end else if (acq_sel_reg == 3'h0) begin
              state_next = ST_CONV;
            end else begin
              state_next = ST_ACQ;
            end
          end
        end
        ST_RC_WAIT: begin
          if (dly_reg <= 7'h01) begin
            state_next = (acq_sel_reg == 3'h0) ? ST_CONV : ST_ACQ;
          end else begin
            dly_next = dly_reg - 7'h01;
          end
        end
        ST_ACQ: begin
          if (period_tick) begin
            if (cnt_reg + 5'h01 >= acq_periods(acq_sel_reg)) begin
              state_next = ST_CONV;
              cnt_next   = 5'h00;
            end else begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (period_tick) begin
            // Periods 1..10 resolve bits MSB first; period 10 also completes
            if (cnt_reg >= 5'h01 && cnt_reg <= 5'h0a) begin
              sar_next[4'(10 - 32'(cnt_reg))] = rc_s2[1];
            end
            if (cnt_reg == 5'(CONV_PERIODS - 1)) begin
              state_next = ST_GAP;
              cnt_next   = 5'h00;
              go_next    = go_set;
              done_next  = 1'b1;
              // Last bit lands this period, so take the updated word
              res_next   = sar_next;
            end else begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        ST_GAP: begin
          if (period_tick) begin
            if (cnt_reg == 5'(WAIT_PERIODS - 1)) begin
              state_next = ST_SAMPLE;
              cnt_next   = 5'h00;
            end else begin
              cnt_next = cnt_reg + 5'h01;
            end
          end
        end
        default: state_next = ST_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_SAMPLE;
      cnt_reg   <= 5'h00;
      dly_reg   <= 7'h00;
      go_reg    <= 1'b0;
      done_reg  <= 1'b0;
      res_reg   <= RESULT_RESET;
      sar_reg   <= 10'h000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      dly_reg   <= dly_next;
      go_reg    <= go_next;
      done_reg  <= done_next;
      res_reg   <= res_next;
      sar_reg   <= sar_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all registered
  // ------------------------------------------------------------
  logic samp_next, conv_next;
  assign samp_next = (state_next == ST_SAMPLE) || (state_next == ST_ACQ) ||
                     (state_next == ST_RC_WAIT);
  assign conv_next = (state_next == ST_CONV);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_enable  <= 1'b1;
      convert_active <= 1'b0;
    end else begin
      sample_enable  <= samp_next;
      convert_active <= conv_next;
    end
  end
  // Go stays set through acquisition and conversion alike
  assign go_flag              = go_reg;
  assign conversion_done_flag = done_reg;
  assign result_register_pair = res_reg;
  assign bit_clock            = bclk_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_hold_disconnect: assert property (@(posedge ref_clk) disable iff (!rst_n)
    convert_active |-> !sample_enable)
    else $error("sampling while converting");
  a_immediate_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_SAMPLE && go_rise && !go_clear && !use_rc &&
     acq_sel_reg == 3'h0) |=> state_reg == ST_CONV)
    else $error("zero acquisition did not start at once");
  a_acq_then_conv: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_ACQ && state_next == ST_CONV) |->
      go_reg && period_tick)
    else $error("acquisition ended off a period");
  a_done_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CONV && state_next == ST_GAP && !go_clear) |=>
      conversion_done_flag && state_reg == ST_GAP)
    else $error("done flag not set at completion");
  a_go_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_ACQ && $past(state_reg) == ST_ACQ) |-> go_reg)
    else $error("go dropped during acquisition");
  a_conv_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CONV && period_tick && cnt_reg == 5'h0a) |=>
      state_reg == ST_GAP)
    else $error("conversion length wrong");
  a_abort_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CONV && go_clear && !go_set && go_reg) |=>
      $stable(result_register_pair) && state_reg == ST_GAP)
    else $error("abort changed result");
  a_rc_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_SAMPLE && state_next == ST_RC_WAIT) |=>
      (state_reg == ST_RC_WAIT || state_reg == ST_GAP) [*4])
    else $error("rc start delay too short");
endmodule : adc_acquisition_clock_sequencer
`default_nettype wire

// >>> rtl/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CONV_PERIODS  = 11;
  localparam int unsigned WAIT_PERIODS  = 2;
  localparam logic [2:0]  ACQ_RESET     = 3'h0;
  localparam logic [2:0]  CLK_SEL_RESET = 3'h0;
  localparam logic [9:0]  RESULT_RESET  = 10'h000;
  // One instruction cycle is four oscillator periods
  localparam int unsigned INSTR_CYCLES  = 4;
  localparam logic [6:0]  INSTR_DELAY   = 7'(INSTR_CYCLES);

  typedef enum logic [4:0] {
    ST_SAMPLE  = 5'h01,
    ST_RC_WAIT = 5'h02,
    ST_ACQ     = 5'h04,
    ST_CONV    = 5'h08,
    ST_GAP     = 5'h10
  } seq_state_t;

  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    case (sel)
      3'h0:    acq_periods = 5'h00;
      3'h1:    acq_periods = 5'h02;
      3'h2:    acq_periods = 5'h04;
      3'h3:    acq_periods = 5'h06;
      3'h4:    acq_periods = 5'h08;
      3'h5:    acq_periods = 5'h0c;
      3'h6:    acq_periods = 5'h10;
      default: acq_periods = 5'h14;
    endcase
  endfunction : acq_periods

  // Half-period of the bit clock in oscillator cycles, minus one
  function automatic logic [6:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0:    div_last = 7'h00;
      3'h4:    div_last = 7'h01;
      3'h1:    div_last = 7'h03;
      3'h5:    div_last = 7'h07;
      3'h2:    div_last = 7'h0f;
      3'h6:    div_last = 7'h1f;
      default: div_last = 7'h00;
    endcase
  endfunction : div_last
endpackage : adc_seq_pkg

// >>> verification/sar_comparator_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Comparator and RC oscillator stand-in
// ----------------------------------------
module sar_comparator_model (
  input  wire logic ref_clk,
  input  wire logic convert_active,
  input  wire logic level,
  output logic      compare_in,
  output var logic  rc_tick
);
  logic toggle_reg;
  initial toggle_reg = 1'b0;
  // Outside a conversion the output means nothing, so it churns
  always @(posedge ref_clk) toggle_reg <= ~toggle_reg;
  assign compare_in = convert_active ? level : toggle_reg;
  // Free-running oscillator, unrelated in phase to ref_clk
  initial rc_tick = 1'b0;
  always #115 rc_tick = ~rc_tick;
endmodule : sar_comparator_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import adc_seq_pkg::*;
  logic            ref_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [2:0]      acquisition_time_select = 3'h0;
  logic [2:0]      conversion_clock_select = 3'h0;
  logic            go_set = 1'b0;
  logic            go_clear = 1'b0;
  logic            done_clear = 1'b0;
  logic            level = 1'b1;
  logic [9:0]      last_res = 10'h000;
  wire logic       rc_tick, compare_in, go_flag, conversion_done_flag;
  wire logic       sample_enable, convert_active, bit_clock;
  wire logic [9:0] result_register_pair;
  wire logic [2:0] acq_sel_reg, clk_sel_reg;
  int              num_errors = 0;
  int              checked = 0;
  int              cycles = 0;
  int              acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int              i;

  always #25 ref_clk = ~ref_clk;

  adc_acquisition_clock_sequencer i_dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .acquisition_time_select(acquisition_time_select),
    .conversion_clock_select(conversion_clock_select), .go_set(go_set),
    .go_clear(go_clear), .done_clear(done_clear), .rc_tick(rc_tick),
    .compare_in(compare_in), .go_flag(go_flag),
    .conversion_done_flag(conversion_done_flag),
    .sample_enable(sample_enable), .convert_active(convert_active),
    .bit_clock(bit_clock), .result_register_pair(result_register_pair),
    .acq_sel_reg(acq_sel_reg), .clk_sel_reg(clk_sel_reg));

  sar_comparator_model i_cmp (.ref_clk(ref_clk),
    .convert_active(convert_active), .level(level),
    .compare_in(compare_in), .rc_tick(rc_tick));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check_val(input string name, input logic [31:0] seen,
                           input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check_val

  task automatic end_sim();
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Longest run is well under 10000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  function automatic int bit_p(input logic [2:0] s);
    case (s)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      default: return 64;
    endcase
  endfunction : bit_p

  // One start with go, optionally aborted after ab_at conversion cycles
  task automatic run(input logic [2:0] a, input logic [2:0] c,
                     input logic lv, input int ab_at);
    int na, ns, nc, ng, nb, k, p;
    bit seen, ab;
    {na, ns, nc, ng, nb, seen, ab} = '0;
    p = bit_p(c);
    @(posedge ref_clk);
    acquisition_time_select <= a;
    conversion_clock_select <= c;
    level <= lv;
    done_clear <= 1'b1;
    @(posedge ref_clk);
    done_clear <= 1'b0;
    go_set <= 1'b1;
    @(negedge ref_clk);
    check_val("done cleared", conversion_done_flag, 0);
    @(posedge ref_clk);
    go_set <= 1'b0;
    for (k = 0; k < 4000; k++) begin
      @(negedge ref_clk);
      if (go_flag === 1'b1) seen = 1;
      if (go_flag === 1'b1 && convert_active !== 1'b1) na++;
      if (go_flag === 1'b1 && convert_active !== 1'b1 &&
          sample_enable === 1'b1) ns++;
      if (convert_active === 1'b1) nc++;
      if (convert_active === 1'b1 && sample_enable !== 1'b0) nb++;
      if (seen && go_flag !== 1'b1 && sample_enable !== 1'b1) ng++;
      if (seen && go_flag !== 1'b1 && sample_enable === 1'b1) break;
      if (ab_at != 0 && nc == ab_at) begin
        ab = 1;
        ab_at = 0;
        @(posedge ref_clk);
        go_clear <= 1'b1;
        @(posedge ref_clk);
        go_clear <= 1'b0;
      end
    end
    if (!ab) last_res = {10{lv}};
    check_val("sample off in conversion", nb, 0);
    check_val("done", conversion_done_flag, !ab);
    check_val("go", go_flag, 0);
    check_val("bit clock idle", bit_clock, 0);
    check_val("result", result_register_pair, last_res);
    if (c[1:0] != 2'b11) begin
      check_val("acq cycles", na, acq_tab[a] * p);
      check_val("sampling in acq", ns, na);
      check_val("gap cycles", ng, WAIT_PERIODS * p);
      if (!ab) check_val("conv cycles", nc, CONV_PERIODS * p);
    end else begin
      check_val("rc start delay", na >= INSTR_CYCLES, 1);
    end
  endtask : run

  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check_val("go at reset", go_flag, 0);
    check_val("sample at reset", sample_enable, 1);
    check_val("acq sel at reset", acq_sel_reg, 0);
    check_val("clk sel at reset", clk_sel_reg, 0);
    // Software lets the channel settle before a code 0 start
    repeat (20) @(posedge ref_clk);
    for (i = 0; i < 8; i++) run(i[2:0], 3'h0, i[0], 0);
    run(3'h0, 3'h4, 1'b1, 0);
    run(3'h0, 3'h1, 1'b0, 0);
    run(3'h0, 3'h5, 1'b1, 0);
    run(3'h0, 3'h2, 1'b0, 0);
    run(3'h0, 3'h6, 1'b1, 0);
    // Nothing else runs during RC conversions, standing in for sleep
    run(3'h0, 3'h3, 1'b1, 0);
    run(3'h2, 3'h7, 1'b0, 0);
    run(3'h0, 3'h1, 1'b1, 40);
    @(posedge ref_clk);
    acquisition_time_select <= 3'h1;
    conversion_clock_select <= 3'h6;
    go_set <= 1'b1;
    @(posedge ref_clk);
    go_set <= 1'b0;
    repeat (30) @(posedge ref_clk);
    reset_n <= 1'b0;
    @(negedge ref_clk);
    check_val("go after reset", go_flag, 0);
    check_val("sample after reset", sample_enable, 1);
    check_val("acq sel after reset", acq_sel_reg, 0);
    check_val("clk sel after reset", clk_sel_reg, 0);
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
